// >>> rtl/lhefpm_flag.sv
// one event flag cleared by writing zero after it was read as one
`timescale 1ns/100ps
module lhefpm_flag (
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic rst,
    // hardware side
    input  wire logic set,
    input  wire logic hw_clr,
    // software side
    input  wire logic rd_one,
    input  wire logic wr,
    input  wire logic wr_val,
    // state
    output logic      flag_q
);

    logic arm_q;

    // ------------------------------------------------------------
    // a read that returned one arms the clear; any write disarms it
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            arm_q <= 1'b0;
        end else if (wr) begin
            arm_q <= 1'b0;
        end else if (rd_one) begin
            arm_q <= 1'b1;
        end
    end

    // set wins over every clear; writing one never sets
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            flag_q <= 1'b0;
        end else if (set) begin
            flag_q <= 1'b1;
        end else if (hw_clr) begin
            flag_q <= 1'b0;
        end else if (wr && !wr_val && arm_q) begin
            flag_q <= 1'b0;
        end
    end

endmodule : lhefpm_flag

// >>> rtl/lhefpm_pkg.sv
// shared constants of the host event flag and pin monitor block
package lhefpm_pkg;

    // ------------------------------------------------------------
    // bus geometry
    // ------------------------------------------------------------
    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 32;
    localparam int          REG_W           = 8;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0]  OFF_IRQ_CONTROL = 8'h00;
    localparam logic [7:0]  OFF_PIN_MONITOR = 8'h04;
    localparam logic [7:0]  OFF_EVT_STATUS  = 8'h08;
    localparam logic [7:0]  OFF_EVT_MASK    = 8'h0c;

    // ------------------------------------------------------------
    // host_if_irq_control fields
    // ------------------------------------------------------------
    localparam int          BIT_A20_MON     = 7;
    localparam int          BIT_RST_EVT     = 6;
    localparam int          BIT_SD_EVT      = 5;
    localparam int          BIT_ABT_EVT     = 4;
    localparam int          BIT_RX3_EN      = 3;
    localparam int          BIT_RX2_EN      = 2;
    localparam int          BIT_RX1_EN      = 1;
    localparam int          BIT_FAULT_EN    = 0;
    localparam int          EN_W            = 4;
    localparam logic [3:0]  EN_RST          = 4'h0;

    // ------------------------------------------------------------
    // synchronised pin vector; bits 7..0 are the monitor layout
    // ------------------------------------------------------------
    localparam int          PIN_W           = 10;
    localparam int          PIN_LFRAME      = 7;
    localparam int          PIN_LRESET      = 4;
    localparam int          PIN_LPCPD       = 3;
    localparam int          PIN_A20         = 8;
    localparam int          PIN_LCLK        = 9;
    localparam logic        SYNC_RST        = 1'b0;
    localparam logic        PIN_IDLE        = 1'b1;

    // ------------------------------------------------------------
    // event status / mask layout
    // ------------------------------------------------------------
    localparam int          ST_RST          = 0;
    localparam int          ST_SD           = 1;
    localparam int          ST_ABT          = 2;
    localparam int          ST_W            = 3;
    localparam logic [2:0]  ST_RST_VAL      = 3'h0;

endpackage : lhefpm_pkg

// >>> rtl/lhefpm_sync.sv
// two-flop synchronisers for the interface pins and the link clock
`timescale 1ns/100ps
module lhefpm_sync
    import lhefpm_pkg::*;
(
    // clock and reset
    input  wire logic             ref_clk,
    input  wire logic             rst,
    // pins
    input  wire logic [PIN_W-1:0] pin_async,
    output logic      [PIN_W-1:0] pin_sync
);

    logic [PIN_W-1:0] meta_q;

    // ------------------------------------------------------------
    // one pair of flops per pin; the first flop feeds only the second
    // ------------------------------------------------------------
    for (genvar i = 0; i < PIN_W; i++) begin : g_bit
        always_ff @(posedge ref_clk) begin
            if (rst) begin
                meta_q[i]   <= SYNC_RST;
                pin_sync[i] <= SYNC_RST;
            end else begin
                meta_q[i]   <= pin_async[i];
                pin_sync[i] <= meta_q[i];
            end
        end
    end

endmodule : lhefpm_sync

// >>> rtl/lhefpm_top.sv
// host interface event flags, interrupt enables and pin monitor
// ------------------------------------------------------------
// Summary of operation
// - control bit 7 mirrors gate A20 pin
// - pin monitors always show live levels
// - reset pin falling edge sets reset flag
// - reset flag clears by zero after one
// - power-down falling edge sets shutdown flag
// - shutdown flag also cleared by LPC resets
// - frame fall mid-cycle sets abort flag
// - abort flag cleared by resets and shutdowns
// - software writes can only clear flags
// - bit 0 gates the fault interrupt
// - bit 1 enables first receive interrupt
// - bit 2 enables second receive interrupt
// - bit 3 enables third and two-way receive
// - monitor register holds eight live pin levels
// ------------------------------------------------------------
//
// Added by the designer: the APB interface to the registers and the register addresses.
`timescale 1ns/100ps
module lhefpm_top
    import lhefpm_pkg::*;
(
    // clock and reset
    input  wire logic              ref_clk,
    input  wire logic              rst,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [DATA_W-1:0] pwdata,
    output logic      [DATA_W-1:0] prdata,
    output logic                   pready,
    output logic                   pslverr,
    // lpc pins, asynchronous
    input  wire logic              lclk,
    input  wire logic              lframe_n,
    input  wire logic              clkrun_n,
    input  wire logic              serirq,
    input  wire logic              lreset_n,
    input  wire logic              lpcpd_n,
    input  wire logic              pme_n,
    input  wire logic              lsmi_n,
    input  wire logic              lsci_n,
    input  wire logic              gate_a_twenty,
    // host interface core, same clock
    input  wire logic              lpc_sw_reset,
    input  wire logic              lpc_sw_shutdown,
    input  wire logic              lpc_cycle_busy,
    input  wire logic              two_way_irq_option,
    input  wire logic              host_input_reg_1_full,
    input  wire logic              host_input_reg_2_full,
    input  wire logic              host_input_reg_3_full,
    input  wire logic              two_way_regs_full,
    // interrupts
    output logic                   host_fault_irq,
    output logic                   rx1_complete_irq,
    output logic                   rx2_complete_irq,
    output logic                   rx3_complete_irq,
    output logic                   evt_irq
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [PIN_W-1:0]  pin_s;
    logic              lclk_prev_q;
    logic              lreset_prev_q;
    logic              lpcpd_prev_q;
    logic              lframe_at_q;
    logic              lclk_rise;
    logic              lreset_fall;
    logic              lpcpd_fall;
    logic              frame_abort;
    logic              lpc_hw_reset;
    logic              lpc_hw_shutdown;
    logic              reset_event_flag;
    logic              shutdown_event_flag;
    logic              abort_event_flag;
    logic [EN_W-1:0]   en_q;
    logic [ST_W-1:0]   evt_status_q;
    logic [ST_W-1:0]   evt_mask_q;
    logic [ST_W-1:0]   evt_pulse;
    logic              setup;
    logic              access;
    logic              wr_ctrl;
    logic              wr_status;
    logic              wr_mask;
    logic              rd_ctrl;
    logic              addr_ok;
    logic [REG_W-1:0]  rd_val;
    logic [DATA_W-1:0] prdata_q;
    logic              pslverr_q;
    logic              fault_q;
    logic [2:0]        rx_q;
    logic              evt_irq_q;

    // ------------------------------------------------------------
    // pin capture
    // ------------------------------------------------------------
    lhefpm_sync u_sync (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .pin_async ({lclk, gate_a_twenty, lframe_n, clkrun_n, serirq,
                     lreset_n, lpcpd_n, pme_n, lsmi_n, lsci_n}),
        .pin_sync  (pin_s)
    );

    // edges are found on synchronised levels, never on the first flop
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            lclk_prev_q   <= SYNC_RST;
            lreset_prev_q <= SYNC_RST;
            lpcpd_prev_q  <= SYNC_RST;
        end else begin
            lclk_prev_q   <= pin_s[PIN_LCLK];
            lreset_prev_q <= pin_s[PIN_LRESET];
            lpcpd_prev_q  <= pin_s[PIN_LPCPD];
        end
    end

    // frame strobe is judged only at link clock rises, as the host drives it
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            lframe_at_q <= PIN_IDLE;
        end else if (lclk_rise) begin
            lframe_at_q <= pin_s[PIN_LFRAME];
        end
    end

    assign lclk_rise       = pin_s[PIN_LCLK] & ~lclk_prev_q;
    assign lreset_fall     = lreset_prev_q & ~pin_s[PIN_LRESET];
    assign lpcpd_fall      = lpcpd_prev_q & ~pin_s[PIN_LPCPD];
    assign frame_abort     = lclk_rise & lframe_at_q & ~pin_s[PIN_LFRAME]
                           & lpc_cycle_busy;
    assign lpc_hw_reset    = ~pin_s[PIN_LRESET];
    assign lpc_hw_shutdown = ~pin_s[PIN_LPCPD];

    // ------------------------------------------------------------
    // event flags
    // ------------------------------------------------------------
    lhefpm_flag u_rst_flag (
        .ref_clk (ref_clk),
        .rst     (rst),
        .set     (lreset_fall),
        .hw_clr  (1'b0),
        .rd_one  (rd_ctrl & prdata_q[BIT_RST_EVT]),
        .wr      (wr_ctrl),
        .wr_val  (pwdata[BIT_RST_EVT]),
        .flag_q  (reset_event_flag)
    );

    lhefpm_flag u_sd_flag (
        .ref_clk (ref_clk),
        .rst     (rst),
        .set     (lpcpd_fall),
        .hw_clr  (lpc_hw_reset | lpc_sw_reset),
        .rd_one  (rd_ctrl & prdata_q[BIT_SD_EVT]),
        .wr      (wr_ctrl),
        .wr_val  (pwdata[BIT_SD_EVT]),
        .flag_q  (shutdown_event_flag)
    );

    lhefpm_flag u_abt_flag (
        .ref_clk (ref_clk),
        .rst     (rst),
        .set     (frame_abort),
        .hw_clr  (lpc_hw_reset | lpc_sw_reset
                  | lpc_hw_shutdown | lpc_sw_shutdown),
        .rd_one  (rd_ctrl & prdata_q[BIT_ABT_EVT]),
        .wr      (wr_ctrl),
        .wr_val  (pwdata[BIT_ABT_EVT]),
        .flag_q  (abort_event_flag)
    );

    // ------------------------------------------------------------
    // apb slave: zero wait states, answer in the first access cycle
    // ------------------------------------------------------------
    assign setup     = psel & ~penable;
    assign access    = psel & penable;
    assign wr_ctrl   = access & pwrite & (paddr == OFF_IRQ_CONTROL);
    assign wr_status = access & pwrite & (paddr == OFF_EVT_STATUS);
    assign wr_mask   = access & pwrite & (paddr == OFF_EVT_MASK);
    assign rd_ctrl   = access & ~pwrite & (paddr == OFF_IRQ_CONTROL);
    assign addr_ok   = (paddr == OFF_IRQ_CONTROL) | (paddr == OFF_PIN_MONITOR)
                     | (paddr == OFF_EVT_STATUS) | (paddr == OFF_EVT_MASK);
    assign pready    = 1'b1;
    assign prdata    = prdata_q;
    assign pslverr   = pslverr_q;

    always_comb begin
        rd_val = '0;
        case (paddr)
            OFF_IRQ_CONTROL: begin
                rd_val[BIT_A20_MON]     = pin_s[PIN_A20];
                rd_val[BIT_RST_EVT]     = reset_event_flag;
                rd_val[BIT_SD_EVT]      = shutdown_event_flag;
                rd_val[BIT_ABT_EVT]     = abort_event_flag;
                rd_val[EN_W-1:0]        = en_q;
            end
            OFF_PIN_MONITOR: begin
                rd_val = pin_s[REG_W-1:0];
            end
            OFF_EVT_STATUS: begin
                rd_val[ST_W-1:0] = evt_status_q;
            end
            OFF_EVT_MASK: begin
                rd_val[ST_W-1:0] = evt_mask_q;
            end
            default: begin
                rd_val = '0;
            end
        endcase
    end

    // read data is frozen at the setup cycle so the flag clear sees what software saw
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            prdata_q  <= '0;
            pslverr_q <= 1'b0;
        end else if (setup) begin
            prdata_q  <= pwrite ? '0 : {{(DATA_W-REG_W){1'b0}}, rd_val};
            pslverr_q <= ~addr_ok;
        end
    end

    // ------------------------------------------------------------
    // enables held in the low control bits
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            en_q <= EN_RST;
        end else if (wr_ctrl) begin
            en_q <= pwdata[EN_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // interrupt requests toward the local processor
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            fault_q <= 1'b0;
            rx_q    <= '0;
        end else begin
            fault_q  <= en_q[BIT_FAULT_EN] & (reset_event_flag
                      | shutdown_event_flag | abort_event_flag);
            rx_q[0]  <= en_q[BIT_RX1_EN] & host_input_reg_1_full;
            rx_q[1]  <= en_q[BIT_RX2_EN] & host_input_reg_2_full;
            rx_q[2]  <= en_q[BIT_RX3_EN] & (host_input_reg_3_full
                      | (two_way_irq_option & two_way_regs_full));
        end
    end

    assign host_fault_irq   = fault_q;
    assign rx1_complete_irq = rx_q[0];
    assign rx2_complete_irq = rx_q[1];
    assign rx3_complete_irq = rx_q[2];

    // ------------------------------------------------------------
    // sticky event status, write one to clear, set wins
    // ------------------------------------------------------------
    assign evt_pulse = {frame_abort, lpcpd_fall, lreset_fall};

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            evt_status_q <= ST_RST_VAL;
        end else if (wr_status) begin
            evt_status_q <= (evt_status_q & ~pwdata[ST_W-1:0]) | evt_pulse;
        end else begin
            evt_status_q <= evt_status_q | evt_pulse;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            evt_mask_q <= ST_RST_VAL;
        end else if (wr_mask) begin
            evt_mask_q <= pwdata[ST_W-1:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            evt_irq_q <= 1'b0;
        end else begin
            evt_irq_q <= |(evt_status_q & evt_mask_q);
        end
    end

    assign evt_irq = evt_irq_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_rst_set;
        @(posedge ref_clk) disable iff (rst)
        lreset_fall |=> reset_event_flag;
    endproperty
    a_rst_set: assert property (p_rst_set) else $error("reset flag not set");

    property p_rst_hold;
        @(posedge ref_clk) disable iff (rst)
        (wr_ctrl && reset_event_flag && !u_rst_flag.arm_q) |=> reset_event_flag;
    endproperty
    a_rst_hold: assert property (p_rst_hold) else $error("reset flag lost");

    property p_sd_set;
        @(posedge ref_clk) disable iff (rst)
        lpcpd_fall |=> shutdown_event_flag;
    endproperty
    a_sd_set: assert property (p_sd_set) else $error("shutdown flag not set");

    property p_sd_clr;
        @(posedge ref_clk) disable iff (rst)
        (lpc_sw_reset && !lpcpd_fall) |=> !shutdown_event_flag;
    endproperty
    a_sd_clr: assert property (p_sd_clr) else $error("shutdown flag kept");

    property p_abt_set;
        @(posedge ref_clk) disable iff (rst)
        frame_abort |=> abort_event_flag;
    endproperty
    a_abt_set: assert property (p_abt_set) else $error("abort flag not set");

    property p_abt_clr;
        @(posedge ref_clk) disable iff (rst)
        (lpc_sw_shutdown && !frame_abort) |=> !abort_event_flag;
    endproperty
    a_abt_clr: assert property (p_abt_clr) else $error("abort flag kept");

    property p_no_sw_set;
        @(posedge ref_clk) disable iff (rst)
        (wr_ctrl && !reset_event_flag && !lreset_fall) |=> !reset_event_flag;
    endproperty
    a_no_sw_set: assert property (p_no_sw_set) else $error("flag set by write");

    property p_fault;
        @(posedge ref_clk) disable iff (rst)
        (en_q[BIT_FAULT_EN] && abort_event_flag) |=> host_fault_irq;
    endproperty
    a_fault: assert property (p_fault) else $error("fault irq missing");

    property p_fault_gate;
        @(posedge ref_clk) disable iff (rst)
        !en_q[BIT_FAULT_EN] |=> !host_fault_irq;
    endproperty
    a_fault_gate: assert property (p_fault_gate) else $error("fault irq ungated");

    property p_rx3;
        @(posedge ref_clk) disable iff (rst)
        (en_q[BIT_RX3_EN] && two_way_irq_option && two_way_regs_full) |=> rx3_complete_irq;
    endproperty
    a_rx3: assert property (p_rx3) else $error("rx3 irq missing");

    property p_monitor;
        @(posedge ref_clk) disable iff (rst)
        (setup && !pwrite && paddr == OFF_PIN_MONITOR)
            |=> prdata[REG_W-1:0] == $past(pin_s[REG_W-1:0]);
    endproperty
    a_monitor: assert property (p_monitor) else $error("monitor read wrong");

    property p_a20_mon;
        @(posedge ref_clk) disable iff (rst)
        (setup && !pwrite && paddr == OFF_IRQ_CONTROL)
            |=> prdata[BIT_A20_MON] == $past(pin_s[PIN_A20]);
    endproperty
    a_a20_mon: assert property (p_a20_mon) else $error("gate a20 read wrong");

endmodule : lhefpm_top

// >>> sim/lhefpm_lpc_host.sv
// lpc host model driving the interface pins of the block
`timescale 1ns/100ps
module lhefpm_lpc_host (
    // pins toward the block
    output logic       lclk,
    output logic       lframe_n,
    output logic       lreset_n,
    output logic       lpcpd_n,
    output logic [5:0] misc
);
    logic run_q = 1'b0;
    initial begin
        lclk = 1'b0;
        lframe_n = 1'b1;
        lreset_n = 1'b1;
        lpcpd_n = 1'b1;
        misc = 6'h3f;
    end
    // the link clock rests low between frames
    always #80 lclk = run_q ? ~lclk : 1'b0;
    task automatic frame();
        run_q = 1'b1;
        repeat (2) @(posedge lclk);
        lframe_n = 1'b0;
        repeat (2) @(posedge lclk);
        lframe_n = 1'b1;
        repeat (2) @(posedge lclk);
        run_q = 1'b0;
    endtask : frame
    // low long enough for the synchronisers to see both edges
    task automatic pulse(input logic pd);
        if (pd) lpcpd_n = 1'b0;
        else lreset_n = 1'b0;
        #400;
        {lpcpd_n, lreset_n} = 2'b11;
    endtask : pulse
endmodule : lhefpm_lpc_host

// >>> sim/test_lhefpm_top.sv
// self-checking bench for the host event flags and pin monitor
`timescale 1ns/100ps
module test_lhefpm_top
    import lhefpm_pkg::*;
;
    logic        ref_clk, rst, psel, penable, pwrite, pready, pslverr, err;
    logic        lclk, lframe_n, lreset_n, lpcpd_n, evt_irq, fault, rx1, rx2, rx3;
    logic        sw_rst, sw_sd, busy, opt;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd, r;
    logic [5:0]  misc;
    logic [3:0]  full, m_en;
    logic [2:0]  m_fl, m_st, m_mk;
    logic [31:0] seed = 32'h00008704;
    int          errors = 0;
    int          n_checks = 0;

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    lhefpm_top dut (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .lclk(lclk), .lframe_n(lframe_n), .lreset_n(lreset_n),
        .lpcpd_n(lpcpd_n), .evt_irq(evt_irq),
        .clkrun_n(misc[4]), .serirq(misc[3]), .pme_n(misc[2]),
        .lsmi_n(misc[1]), .lsci_n(misc[0]), .gate_a_twenty(misc[5]), .lpc_sw_reset(sw_rst),
        .lpc_sw_shutdown(sw_sd), .lpc_cycle_busy(busy), .two_way_irq_option(opt),
        .host_input_reg_1_full(full[0]), .host_input_reg_2_full(full[1]),
        .host_input_reg_3_full(full[2]), .two_way_regs_full(full[3]),
        .host_fault_irq(fault), .rx1_complete_irq(rx1), .rx2_complete_irq(rx2),
        .rx3_complete_irq(rx3));
    lhefpm_lpc_host host (.lclk(lclk), .lframe_n(lframe_n), .lreset_n(lreset_n),
        .lpcpd_n(lpcpd_n), .misc(misc));

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            errors++;
            $display("[ERR] %0t apb answer timeout", $time);
            test_done();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic check_all(input string what);
        apb(1'b0, OFF_IRQ_CONTROL, 32'h0);
        chk(rd, {24'h0, misc[5], m_fl, m_en}, what);
        apb(1'b0, OFF_EVT_STATUS, 32'h0);
        chk(rd, {29'h0, m_st}, what);
        repeat (2) @(posedge ref_clk);
        chk({27'h0, fault, rx1, rx2, rx3, evt_irq}, {27'h0, m_en[0] & (|m_fl),
            m_en[1] & full[0], m_en[2] & full[1], m_en[3] & (full[2] | (opt & full[3])),
            |(m_st & m_mk)}, what);
    endtask : check_all

    task automatic step(input int k);
        case (k)
            0: begin
                host.pulse(1'b0);
                m_fl = 3'b100;
                m_st |= 3'h1;
            end
            1: begin
                host.pulse(1'b1);
                m_fl = {m_fl[2], 2'b10};
                m_st |= 3'h2;
            end
            2, 3: begin
                @(posedge ref_clk);
                {sw_rst, sw_sd} <= (k == 2) ? 2'b10 : 2'b01;
                @(posedge ref_clk);
                {sw_rst, sw_sd} <= 2'b00;
                if (k == 2) m_fl[1] = 1'b0;
                m_fl[0] = 1'b0;
            end
            4, 5: begin
                @(posedge ref_clk);
                busy <= (k == 4);
                host.frame();
                @(posedge ref_clk);
                busy <= 1'b0;
                if (k == 4) m_fl[0] = 1'b1;
                if (k == 4) m_st |= 3'h4;
            end
            default: begin
                apb(1'b1, OFF_IRQ_CONTROL, {28'h0, m_en});
                m_fl = 3'b000;
            end
        endcase
    endtask : step

    task automatic test_done();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : test_done

    initial begin
        #200000;
        errors++;
        test_done();
    end

    initial begin
        int seq[13] = '{5, 4, 1, 4, 3, 4, 2, 1, 0, 6, 1, 4, 6};
        {rst, psel, penable, pwrite, sw_rst, sw_sd, busy, opt} = 8'h80;
        paddr = 8'h00;
        pwdata = 32'h0;
        full = 4'h0;
        {m_en, m_fl, m_st, m_mk} = 13'h0005;
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (5) @(posedge ref_clk);
        apb(1'b1, OFF_EVT_MASK, {29'h0, m_mk});
        // flag bits get random ones here, which must never set a flag
        for (int i = 0; i < 8; i++) begin
            r = xs();
            host.misc <= r[5:0];
            full <= r[9:6];
            opt <= r[10];
            m_en = r[14:11];
            apb(1'b1, OFF_IRQ_CONTROL, {24'h0, r[18:11]});
            repeat (4) @(posedge ref_clk);
            apb(1'b0, OFF_PIN_MONITOR, 32'h0);
            chk(rd, {24'h0, 1'b1, misc[4:3], 2'b11, misc[2:0]}, "pins");
            check_all("enables");
        end
        $display("pin and enable test done");
        m_en = 4'h1;
        apb(1'b1, OFF_IRQ_CONTROL, 32'h71);
        step(0);
        apb(1'b1, OFF_IRQ_CONTROL, 32'h01);
        check_all("clear without read");
        m_en = 4'h0;
        apb(1'b1, OFF_IRQ_CONTROL, 32'h70);
        check_all("fault gated");
        m_en = 4'h1;
        apb(1'b1, OFF_IRQ_CONTROL, 32'h71);
        foreach (seq[j]) begin
            step(seq[j]);
            check_all("event");
        end
        apb(1'b1, OFF_EVT_STATUS, 32'h1);
        m_st &= 3'h6;
        check_all("status part clear");
        apb(1'b1, OFF_EVT_STATUS, 32'h7);
        m_st = 3'h0;
        check_all("status clear");
        apb(1'b0, 8'h10, 32'h0);
        chk({31'h0, err}, 32'h1, "unmapped error");
        chk(rd, 32'h0, "unmapped data");
        $display("event and status test done");
        test_done();
    end
endmodule : test_lhefpm_top
